// [atm_pkg.sv]
package atm_pkg;
    // slave mode select codes
    localparam logic [2:0] SM_OFF      = 3'h0;
    localparam logic [2:0] SM_ENC_ONE  = 3'h1;
    localparam logic [2:0] SM_ENC_TWO  = 3'h2;
    localparam logic [2:0] SM_ENC_BOTH = 3'h3;
    localparam logic [2:0] SM_RESET    = 3'h4;
    localparam logic [2:0] SM_GATED    = 3'h5;
    localparam logic [2:0] SM_TRIGGER  = 3'h6;
    // compare output mode codes and output direction select code
    localparam logic [2:0] OCM_FROZEN      = 3'h0;
    localparam logic [2:0] OCM_MATCH_ACT   = 3'h1;
    localparam logic [2:0] OCM_MATCH_INACT = 3'h2;
    localparam logic [2:0] OCM_TOGGLE      = 3'h3;
    localparam logic [2:0] OCM_FORCE_INACT = 3'h4;
    localparam logic [2:0] OCM_FORCE_ACT   = 3'h5;
    localparam logic [2:0] OCM_PWM1        = 3'h6;
    localparam logic [2:0] OCM_PWM2        = 3'h7;
    localparam logic [1:0] DIR_SEL_OUTPUT  = 2'h0;
    // counter direction encoding, 0 counts up
    localparam logic       DIR_UP          = 1'b0;
    localparam logic       DIR_DOWN        = 1'b1;
    // reset values and channel counts
    localparam logic       RST_RUN         = 1'b0;
    localparam logic       RST_MOE         = 1'b0;
    localparam logic       RST_REF         = 1'b0;
    localparam int         NUM_PAIRS       = 3;
    localparam int         NUM_INPUTS      = 2;
endpackage : atm_pkg

// [atm_top.sv]
// Function
// - pwm input measurement on channels one, two
// - one input, second channel opposite edge
// - single pulse halts counter at update
// - single pulse delay and width from compare
// - both enables off inactive, both on drive
// - main enable low drives idle levels
// - per-output polarity, one means active low
// - brake from clock fail or input, gated
// - outputs of a pair never active together with main enable on
// - dead-time field sets dead length
// - forced reference modes, events still produced
// - encoder edge select, polarity, filter per input
// - encoder direction from edge and other level
// - encoder recomputes direction on every transition
// - slave codes reset, gated, trigger start
// - reset mode reinitialises counter, issues update
// - gated mode pauses counter while trigger low
// - trigger rising edge starts counter only
// - update, trigger, compare, brake events raised
// - external trigger clears reference until update
// - trigger output lets timers chain
// - trigger mode sets run enable itself
`timescale 1ns/100ps
module atm_top
    import atm_pkg::*;
#(
    parameter int CW  = 16,
    parameter int DTW = 8,
    parameter int FW  = 4
) (
    // clock and reset
    input  wire logic                          CLK,
    input  wire logic                          RST,
    // counter control
    input  wire logic                          CNT_TICK,
    input  wire logic [2:0]                    SLAVE_MODE_SELECT,
    input  wire logic                          SINGLE_PULSE_ENABLE,
    input  wire logic                          COUNT_DIRECTION_SW,
    input  wire logic                          COUNTER_RUN_SET,
    input  wire logic                          COUNTER_RUN_CLEAR,
    input  wire logic [CW-1:0]                 AUTO_RELOAD_VALUE,
    input  wire logic                          SELECTED_TRIGGER_INPUT,
    // inputs and measurement
    input  wire logic                          CHANNEL_ONE_PIN,
    input  wire logic                          CHANNEL_TWO_PIN,
    input  wire logic [FW-1:0]                 INPUT_ONE_FILTER,
    input  wire logic [FW-1:0]                 INPUT_TWO_FILTER,
    input  wire logic                          PWM_INPUT_MODE,
    // channel configuration
    input  wire logic [NUM_PAIRS-1:0][CW-1:0]  CAPTURE_COMPARE_VALUE,
    input  wire logic [NUM_PAIRS-1:0][1:0]     CHANNEL_DIRECTION_SELECT,
    input  wire logic [NUM_PAIRS-1:0][2:0]     COMPARE_OUTPUT_MODE,
    input  wire logic [NUM_PAIRS-1:0]          REFERENCE_CLEAR_ENABLE,
    input  wire logic                          FILTERED_EXTERNAL_TRIGGER,
    // output stage configuration
    input  wire logic [NUM_PAIRS-1:0]          CHANNEL_OUTPUT_ENABLE,
    input  wire logic [NUM_PAIRS-1:0]          COMPLEMENTARY_OUTPUT_ENABLE,
    input  wire logic [NUM_PAIRS-1:0]          CHANNEL_POLARITY,
    input  wire logic [NUM_PAIRS-1:0]          COMPLEMENTARY_POLARITY,
    input  wire logic [NUM_PAIRS-1:0]          IDLE_OUTPUT_STATE,
    input  wire logic [NUM_PAIRS-1:0]          COMPLEMENTARY_IDLE_STATE,
    input  wire logic [DTW-1:0]                DEAD_TIME_SETTING,
    input  wire logic                          MAIN_OUTPUT_ENABLE_SET,
    input  wire logic                          MAIN_OUTPUT_ENABLE_CLEAR,
    // brake
    input  wire logic                          BRAKE_ENABLE,
    input  wire logic                          BRAKE_POLARITY,
    input  wire logic                          BRAKE_IN,
    input  wire logic                          CLOCK_FAIL,
    // status
    output logic [CW-1:0]                      COUNTER_VALUE,
    output logic                               COUNT_DIRECTION,
    output logic                               COUNTER_RUN_ENABLE,
    output logic                               MAIN_OUTPUT_ENABLE,
    output logic [CW-1:0]                      CAPTURE_ONE_VALUE,
    output logic [CW-1:0]                      CAPTURE_TWO_VALUE,
    // events
    output logic                               UPDATE_EVENT,
    output logic                               TRIGGER_EVENT,
    output logic                               TRIGGER_OUT,
    output logic                               BRAKE_EVENT,
    output logic [NUM_PAIRS-1:0]               COMPARE_EVENT,
    output logic [NUM_INPUTS-1:0]              CAPTURE_EVENT,
    // pins
    output logic [NUM_PAIRS-1:0]               CHANNEL_OUT,
    output logic [NUM_PAIRS-1:0]               COMPLEMENTARY_OUT
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    // input filters: a level must hold filter+1 samples
    logic [NUM_INPUTS-1:0]        raw_in, filt_q, filt_d, pol_in;
    logic [NUM_INPUTS-1:0][FW-1:0] filt_len, fcnt_q, fcnt_d;
    assign raw_in   = {CHANNEL_TWO_PIN, CHANNEL_ONE_PIN};
    assign filt_len = {INPUT_TWO_FILTER, INPUT_ONE_FILTER};
    genvar gi;
    for (gi = 0; gi < NUM_INPUTS; gi++) begin : g_filt
        always_comb begin
            filt_d[gi] = filt_q[gi];
            fcnt_d[gi] = '0;
            if (raw_in[gi] != filt_q[gi]) begin
                if (fcnt_q[gi] >= filt_len[gi]) begin
                    filt_d[gi] = raw_in[gi];
                end else begin
                    fcnt_d[gi] = fcnt_q[gi] + 1'b1;
                end
            end
        end
        always_ff @(posedge CLK) begin
            if (RST) begin
                filt_q[gi] <= 1'b0;
                fcnt_q[gi] <= '0;
            end else begin
                filt_q[gi] <= filt_d[gi];
                fcnt_q[gi] <= fcnt_d[gi];
            end
        end
        assign pol_in[gi] = filt_q[gi] ^ CHANNEL_POLARITY[gi];
    end

    logic filtered_input_one, filtered_input_two, in_prev_one_q, in_prev_two_q;
    logic edge_one, edge_two, enc_up, is_enc;
    assign filtered_input_one = pol_in[0];
    assign filtered_input_two = pol_in[1];
    assign edge_one = filtered_input_one ^ in_prev_one_q;
    assign edge_two = filtered_input_two ^ in_prev_two_q;
    // edge on one: up when levels differ; edge on two: up when equal
    assign enc_up = edge_one ? (filtered_input_one ^ filtered_input_two)
                             : ~(filtered_input_one ^ filtered_input_two);
    assign is_enc = (SLAVE_MODE_SELECT == SM_ENC_ONE) || (SLAVE_MODE_SELECT == SM_ENC_TWO)
                 || (SLAVE_MODE_SELECT == SM_ENC_BOTH);

    // counter, slave controller and brake
    logic [CW-1:0] cnt_q, cnt_d, cap1_q, cap1_d, cap2_q, cap2_d;
    logic run_q, run_d, dir_q, dir_d, moe_q, moe_d, trg_prev_q, brk_prev_q;
    logic upd_q, upd_d, trg_q, trg_d, bev_q, bev_d, step, step_up, enc_ev, trig_rise, brk;
    logic [1:0] capev_q, capev_d;
    assign trig_rise = SELECTED_TRIGGER_INPUT & ~trg_prev_q;
    assign brk = BRAKE_ENABLE & ((BRAKE_IN == BRAKE_POLARITY) | CLOCK_FAIL);

    always_comb begin
        run_d   = run_q;
        dir_d   = is_enc ? dir_q : COUNT_DIRECTION_SW;
        cnt_d   = cnt_q;
        upd_d   = 1'b0;
        trg_d   = 1'b0;
        cap1_d  = cap1_q;
        cap2_d  = cap2_q;
        capev_d = 2'b00;
        enc_ev  = 1'b0;
        unique case (SLAVE_MODE_SELECT)
            SM_ENC_ONE:  enc_ev = edge_one;
            SM_ENC_TWO:  enc_ev = edge_two;
            SM_ENC_BOTH: enc_ev = edge_one | edge_two;
            default:     enc_ev = 1'b0;
        endcase
        if (is_enc && (edge_one || edge_two)) begin
            dir_d = enc_up ? DIR_UP : DIR_DOWN;
        end
        if (COUNTER_RUN_SET) begin
            run_d = 1'b1;
        end else if (COUNTER_RUN_CLEAR) begin
            run_d = 1'b0;
        end
        step    = run_q & (is_enc ? enc_ev
                  : CNT_TICK & ((SLAVE_MODE_SELECT != SM_GATED) | SELECTED_TRIGGER_INPUT));
        step_up = is_enc ? enc_up : (dir_q == DIR_UP);
        if ((SLAVE_MODE_SELECT == SM_RESET) && trig_rise) begin
            cnt_d = (dir_q == DIR_UP) ? '0 : AUTO_RELOAD_VALUE;
            upd_d = 1'b1;
            trg_d = 1'b1;
        end else if (step) begin
            if (step_up) begin
                cnt_d = (cnt_q == AUTO_RELOAD_VALUE) ? '0 : cnt_q + 1'b1;
                upd_d = (cnt_q == AUTO_RELOAD_VALUE);
            end else begin
                cnt_d = (cnt_q == '0) ? AUTO_RELOAD_VALUE : cnt_q - 1'b1;
                upd_d = (cnt_q == '0);
            end
        end
        if (upd_d && SINGLE_PULSE_ENABLE) begin
            run_d = 1'b0;
        end
        if ((SLAVE_MODE_SELECT == SM_TRIGGER) && trig_rise) begin
            run_d = 1'b1;
            trg_d = 1'b1;
        end
        if ((SLAVE_MODE_SELECT == SM_GATED)
            && (SELECTED_TRIGGER_INPUT != trg_prev_q)) begin
            trg_d = 1'b1;
        end
        // measurement uses channel one input for both captures
        if (PWM_INPUT_MODE && edge_one) begin
            if (filtered_input_one) begin
                cap1_d     = cnt_q;
                capev_d[0] = 1'b1;
            end else begin
                cap2_d     = cnt_q;
                capev_d[1] = 1'b1;
            end
        end
        moe_d = moe_q;
        if (brk) begin
            moe_d = 1'b0;
        end else if (MAIN_OUTPUT_ENABLE_SET) begin
            moe_d = 1'b1;
        end else if (MAIN_OUTPUT_ENABLE_CLEAR) begin
            moe_d = 1'b0;
        end
        bev_d = brk & ~brk_prev_q;
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            cnt_q         <= '0;
            run_q         <= RST_RUN;
            dir_q         <= DIR_UP;
            moe_q         <= RST_MOE;
            upd_q         <= 1'b0;
            trg_q         <= 1'b0;
            bev_q         <= 1'b0;
            cap1_q        <= '0;
            cap2_q        <= '0;
            capev_q       <= 2'b00;
            trg_prev_q    <= 1'b0;
            brk_prev_q    <= 1'b0;
            // idle input level, so no false edge right after reset
            in_prev_one_q <= CHANNEL_POLARITY[0];
            in_prev_two_q <= CHANNEL_POLARITY[1];
        end else begin
            cnt_q         <= cnt_d;
            run_q         <= run_d;
            dir_q         <= dir_d;
            moe_q         <= moe_d;
            upd_q         <= upd_d;
            trg_q         <= trg_d;
            bev_q         <= bev_d;
            cap1_q        <= cap1_d;
            cap2_q        <= cap2_d;
            capev_q       <= capev_d;
            trg_prev_q    <= SELECTED_TRIGGER_INPUT;
            brk_prev_q    <= brk;
            in_prev_one_q <= filtered_input_one;
            in_prev_two_q <= filtered_input_two;
        end
    end

    assign COUNTER_VALUE      = cnt_q;
    assign COUNT_DIRECTION    = dir_q;
    assign COUNTER_RUN_ENABLE = run_q;
    assign MAIN_OUTPUT_ENABLE = moe_q;
    assign CAPTURE_ONE_VALUE  = cap1_q;
    assign CAPTURE_TWO_VALUE  = cap2_q;
    assign UPDATE_EVENT       = upd_q;
    assign TRIGGER_OUT        = upd_q;
    assign TRIGGER_EVENT      = trg_q;
    assign BRAKE_EVENT        = bev_q;
    assign CAPTURE_EVENT      = capev_q;

    // compare reference, clear, dead time and output stage per pair
    genvar gc;
    for (gc = 0; gc < NUM_PAIRS; gc++) begin : g_ch
        logic [CW-1:0]  ccv;
        logic [DTW-1:0] dtc_q, dtc_d;
        logic ref_q, ref_d, clr_q, clr_d, refp_q, ref_eff, stable, dt_done;
        logic act_m, act_n, out_q, out_d, outn_q, outn_d, cev_q, cev_d;
        assign ccv     = CAPTURE_COMPARE_VALUE[gc];
        assign ref_eff = ref_q & ~clr_q;
        assign stable  = (ref_eff == refp_q);
        // a zero setting adds no delay; otherwise the new level waits
        assign dt_done = (DEAD_TIME_SETTING == '0)
                      || (stable && (dtc_q >= DEAD_TIME_SETTING - 1'b1));
        assign act_m   = ref_eff & dt_done;
        assign act_n   = ~ref_eff & dt_done;
        always_comb begin
            ref_d = ref_q;
            if (CHANNEL_DIRECTION_SELECT[gc] != DIR_SEL_OUTPUT) begin
                ref_d = RST_REF;
            end else begin
                unique case (COMPARE_OUTPUT_MODE[gc])
                    OCM_FROZEN:      ref_d = ref_q;
                    OCM_MATCH_ACT:   ref_d = (cnt_q == ccv) ? 1'b1 : ref_q;
                    OCM_MATCH_INACT: ref_d = (cnt_q == ccv) ? 1'b0 : ref_q;
                    OCM_TOGGLE:      ref_d = (cnt_q == ccv) ? ~ref_q : ref_q;
                    OCM_FORCE_INACT: ref_d = 1'b0;
                    OCM_FORCE_ACT:   ref_d = 1'b1;
                    // frozen counter after a single pulse freezes this too
                    OCM_PWM1:        ref_d = (cnt_q < ccv);
                    OCM_PWM2:        ref_d = ~(cnt_q < ccv);
                endcase
            end
            clr_d = upd_d ? 1'b0 : clr_q;
            if (REFERENCE_CLEAR_ENABLE[gc] && FILTERED_EXTERNAL_TRIGGER) begin
                clr_d = 1'b1;
            end
            dtc_d = stable ? ((dtc_q == '1) ? dtc_q : dtc_q + 1'b1) : '0;
            cev_d = (cnt_d == ccv) && (cnt_d != cnt_q);
            if (!moe_q) begin
                out_d  = IDLE_OUTPUT_STATE[gc];
                outn_d = COMPLEMENTARY_IDLE_STATE[gc];
            end else begin
                out_d  = CHANNEL_POLARITY[gc];
                outn_d = COMPLEMENTARY_POLARITY[gc];
                if (CHANNEL_OUTPUT_ENABLE[gc]) begin
                    out_d = act_m ^ CHANNEL_POLARITY[gc];
                end
                if (COMPLEMENTARY_OUTPUT_ENABLE[gc]) begin
                    outn_d = act_n ^ COMPLEMENTARY_POLARITY[gc];
                end
            end
        end
        always_ff @(posedge CLK) begin
            if (RST) begin
                ref_q  <= RST_REF;
                refp_q <= RST_REF;
                clr_q  <= 1'b0;
                dtc_q  <= '0;
                cev_q  <= 1'b0;
                out_q  <= 1'b0;
                outn_q <= 1'b0;
            end else begin
                ref_q  <= ref_d;
                refp_q <= ref_eff;
                clr_q  <= clr_d;
                dtc_q  <= dtc_d;
                cev_q  <= cev_d;
                out_q  <= out_d;
                outn_q <= outn_d;
            end
        end
        assign CHANNEL_OUT[gc]       = out_q;
        assign COMPLEMENTARY_OUT[gc] = outn_q;
        assign COMPARE_EVENT[gc]     = cev_q;

        property p_no_overlap;
            moe_q && CHANNEL_OUTPUT_ENABLE[gc] && COMPLEMENTARY_OUTPUT_ENABLE[gc]
            |=> !((CHANNEL_OUT[gc] ^ $past(CHANNEL_POLARITY[gc]))
                && (COMPLEMENTARY_OUT[gc] ^ $past(COMPLEMENTARY_POLARITY[gc])));
        endproperty
        a_no_overlap: assert property (p_no_overlap) else $error("pair both active");
        property p_force_act;
            (CHANNEL_DIRECTION_SELECT[gc] == DIR_SEL_OUTPUT)
            && (COMPARE_OUTPUT_MODE[gc] == OCM_FORCE_ACT) |=> ref_q;
        endproperty
        a_force_act: assert property (p_force_act) else $error("force active lost");
        property p_ref_clear;
            REFERENCE_CLEAR_ENABLE[gc] && FILTERED_EXTERNAL_TRIGGER |=> !ref_eff ##1 1'b1;
        endproperty
        a_ref_clear: assert property (p_ref_clear) else $error("reference not cleared");
    end

    property p_brake_moe;
        brk |=> !moe_q ##1 !MAIN_OUTPUT_ENABLE || !$past(brk);
    endproperty
    a_brake_moe: assert property (p_brake_moe) else $error("brake left outputs on");
    property p_idle_level;
        !moe_q |=> CHANNEL_OUT == $past(IDLE_OUTPUT_STATE);
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("idle level wrong");
    property p_single_pulse;
        upd_d && SINGLE_PULSE_ENABLE && !COUNTER_RUN_SET
        && !((SLAVE_MODE_SELECT == SM_TRIGGER) && trig_rise) |=> !COUNTER_RUN_ENABLE;
    endproperty
    a_single_pulse: assert property (p_single_pulse) else $error("counter kept running");
    property p_reset_mode;
        (SLAVE_MODE_SELECT == SM_RESET) && trig_rise && (dir_q == DIR_UP)
        |=> UPDATE_EVENT && TRIGGER_EVENT && (COUNTER_VALUE == '0);
    endproperty
    a_reset_mode: assert property (p_reset_mode) else $error("reset mode missed");
    property p_gated_pause;
        (SLAVE_MODE_SELECT == SM_GATED) && !SELECTED_TRIGGER_INPUT |=> $stable(COUNTER_VALUE);
    endproperty
    a_gated_pause: assert property (p_gated_pause) else $error("gated count moved");
    property p_trig_start;
        (SLAVE_MODE_SELECT == SM_TRIGGER) && trig_rise |=> COUNTER_RUN_ENABLE && TRIGGER_EVENT;
    endproperty
    a_trig_start: assert property (p_trig_start) else $error("trigger did not start");
    property p_enc_dir;
        is_enc && edge_one && filtered_input_one && !filtered_input_two
        |=> COUNT_DIRECTION == DIR_UP;
    endproperty
    a_enc_dir: assert property (p_enc_dir) else $error("encoder direction wrong");
endmodule : atm_top

// [atm_enc_model.sv]
`timescale 1ns/100ps
module atm_enc_model (
    // clock
    input  wire logic CLK,
    // encoder and measured pwm lines
    output logic      PIN_A,
    output logic      PIN_B
);
    logic [1:0] ph = 2'h0;
    initial {PIN_A, PIN_B} = 2'h0;
    // one quadrature step; order 00,10,11,01 counts up
    task automatic step(input logic fwd);
        ph = fwd ? ph + 2'h1 : ph - 2'h1;
        @(posedge CLK);
        PIN_A <= ph[1] ^ ph[0];
        PIN_B <= ph[1];
        // slow spacing so the filter and edge stage settle
        repeat (6) @(posedge CLK);
    endtask : step
    // one high pulse of h cycles on the first line
    task automatic pwm(input int h);
        @(posedge CLK);
        PIN_A <= 1'b0;
        repeat (6) @(posedge CLK);
        PIN_A <= 1'b1;
        repeat (h) @(posedge CLK);
        PIN_A <= 1'b0;
        repeat (6) @(posedge CLK);
    endtask : pwm
endmodule : atm_enc_model

// [tb_top.sv]
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_top
    import atm_pkg::*;
;
    // stimulus
    logic             clk = 1'b0, rst = 1'b1;
    logic             tick, spe, dsw, rset, rclr, sti, pim, fet, mset, ben, bin, cfail, bpol, mclr;
    logic [2:0]       sms, rce, coe, cne, cpol, npol, ios, nis;
    logic [15:0]      arv;
    logic [2:0][15:0] ccv;
    logic [2:0][2:0]  com;
    logic [2:0][1:0]  cds;
    logic [7:0]       dead_time_setting;
    // observed
    logic [15:0]      cnt, cap1, cap2;
    logic             dir, run, moe, upd, trg, brk, pa, pb, tro;
    logic [1:0]       cpe;
    logic [2:0]       cmp, cho, cmo;
    int               fail_count, n_tests, upd_n, trg_n, brk_n, cmp_n, n1, n5, tro_n, cap_n;
    bit               ovl;

    always #5 clk = ~clk;

    atm_enc_model i_atm_enc_model (.CLK(clk), .PIN_A(pa), .PIN_B(pb));

    atm_top i_atm_top (
        .CLK(clk), .RST(rst), .CNT_TICK(tick), .SLAVE_MODE_SELECT(sms),
        .SINGLE_PULSE_ENABLE(spe), .COUNT_DIRECTION_SW(dsw), .COUNTER_RUN_SET(rset),
        .COUNTER_RUN_CLEAR(rclr), .AUTO_RELOAD_VALUE(arv), .SELECTED_TRIGGER_INPUT(sti),
        .CHANNEL_ONE_PIN(pa), .CHANNEL_TWO_PIN(pb), .INPUT_ONE_FILTER(4'h0),
        .INPUT_TWO_FILTER(4'h0), .PWM_INPUT_MODE(pim), .CAPTURE_COMPARE_VALUE(ccv),
        .CHANNEL_DIRECTION_SELECT(cds), .COMPARE_OUTPUT_MODE(com),
        .REFERENCE_CLEAR_ENABLE(rce), .FILTERED_EXTERNAL_TRIGGER(fet),
        .CHANNEL_OUTPUT_ENABLE(coe), .COMPLEMENTARY_OUTPUT_ENABLE(cne),
        .CHANNEL_POLARITY(cpol), .COMPLEMENTARY_POLARITY(npol), .IDLE_OUTPUT_STATE(ios),
        .COMPLEMENTARY_IDLE_STATE(nis), .DEAD_TIME_SETTING(dead_time_setting),
        .MAIN_OUTPUT_ENABLE_SET(mset), .MAIN_OUTPUT_ENABLE_CLEAR(mclr),
        .BRAKE_ENABLE(ben), .BRAKE_POLARITY(bpol), .BRAKE_IN(bin), .CLOCK_FAIL(cfail),
        .COUNTER_VALUE(cnt), .COUNT_DIRECTION(dir), .COUNTER_RUN_ENABLE(run),
        .MAIN_OUTPUT_ENABLE(moe), .CAPTURE_ONE_VALUE(cap1), .CAPTURE_TWO_VALUE(cap2),
        .UPDATE_EVENT(upd), .TRIGGER_EVENT(trg), .TRIGGER_OUT(tro), .BRAKE_EVENT(brk),
        .COMPARE_EVENT(cmp), .CAPTURE_EVENT(cpe), .CHANNEL_OUT(cho), .COMPLEMENTARY_OUT(cmo)
    );

    // event pulses are single cycle, so count them at every edge
    always @(posedge clk) begin
        upd_n += int'(upd);
        trg_n += int'(trg);
        brk_n += int'(brk);
        cmp_n += int'(cmp[0]);
        tro_n += int'(tro);
        cap_n += int'(cpe[0]) + int'(cpe[1]);
        if (moe && |((cho ^ cpol) & (cmo ^ npol) & coe & cne)) ovl = 1'b1;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic ticks(input int n);
        tick <= 1'b1;
        cyc(n);
        tick <= 1'b0;
        cyc(3);
    endtask : ticks

    task automatic enc(input logic [2:0] m, input int n, input logic fwd, input logic [15:0] e);
        sms <= m;
        repeat (n) i_atm_enc_model.step(fwd);
        cyc(4);
        `CHK(cnt, e)
        `CHK(dir, fwd ? DIR_UP : DIR_DOWN)
    endtask : enc

    task automatic dead(input logic [7:0] d, output int n);
        dead_time_setting <= d;
        com[0] <= OCM_FORCE_ACT;
        cyc(20);
        com[0] <= OCM_FORCE_INACT;
        n = 0;
        while (cmo[0] !== 1'b1 && n < 40) begin
            cyc(1);
            n++;
        end
    endtask : dead

    task automatic finish_test();
        $display("tests=%0d errors=%0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test

    initial begin
        #200us;
        fail_count++;
        finish_test();
    end

    initial begin
        {tick, spe, dsw, rset, rclr, sti, pim, fet, mset, ben, bin, cfail, bpol, mclr} = '0;
        {sms, rce, coe, cne, cpol, npol, ios, nis, ccv, com, dead_time_setting, cds} = '0;
        arv = 16'h0003;
        cyc(5);
        rst <= 1'b0;
        cyc(2);
        `CHK(moe, 1'b0)
        ccv[0] <= 16'h0002;
        com[0] <= OCM_FORCE_INACT;
        rset <= 1'b1;
        cyc(1);
        rset <= 1'b0;
        cyc(2);
        ticks(5);
        `CHK(cnt, 16'h0001)
        `CHK(upd_n, 1)
        `CHK(cmp_n, 1)
        spe <= 1'b1;
        ticks(8);
        `CHK(run, 1'b0)
        `CHK(cnt, 16'h0000)
        `CHK(upd_n, 2)
        spe <= 1'b0;
        // gated mode still needs software run enable
        sms <= SM_GATED;
        rset <= 1'b1;
        cyc(1);
        rset <= 1'b0;
        ticks(3);
        `CHK(cnt, 16'h0000)
        sti <= 1'b1;
        cyc(2);
        ticks(3);
        `CHK(cnt, 16'h0003)
        sti <= 1'b0;
        cyc(2);
        ticks(2);
        `CHK(cnt, 16'h0003)
        sms <= SM_RESET;
        cyc(2);
        sti <= 1'b1;
        cyc(3);
        `CHK(cnt, 16'h0000)
        `CHK(upd_n, 3)
        `CHK(tro_n, 3)
        rclr <= 1'b1;
        sti <= 1'b0;
        cyc(1);
        rclr <= 1'b0;
        cyc(2);
        sms <= SM_TRIGGER;
        ticks(2);
        `CHK(run, 1'b0)
        sti <= 1'b1;
        cyc(3);
        `CHK(run, 1'b1)
        ticks(2);
        `CHK(cnt, 16'h0002)
        `CHK(trg_n, 4)
        // second reset in mid-run, with no slave mode armed
        sms <= SM_OFF;
        rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
        arv <= 16'h00ff;
        rset <= 1'b1;
        cyc(1);
        rset <= 1'b0;
        enc(SM_ENC_BOTH, 4, 1'b1, 16'h0004);
        enc(SM_ENC_BOTH, 2, 1'b0, 16'h0002);
        enc(SM_ENC_ONE, 4, 1'b1, 16'h0004);
        enc(SM_ENC_TWO, 4, 1'b1, 16'h0006);
        sms <= SM_RESET;
        pim <= 1'b1;
        sti <= 1'b0;
        tick <= 1'b1;
        i_atm_enc_model.pwm(9);
        tick <= 1'b0;
        cyc(2);
        `CHK(cap2 - cap1, 16'h0009)
        `CHK(cap_n, 3)
        ios <= 3'h5;
        nis <= 3'h2;
        cyc(3);
        `CHK({cho, cmo}, 6'h2a)
        com <= {OCM_FORCE_ACT, OCM_FORCE_INACT, OCM_FORCE_ACT};
        {coe, cne, cpol} <= {3'h7, 3'h7, 3'h4};
        mset <= 1'b1;
        cyc(1);
        mset <= 1'b0;
        cyc(6);
        `CHK(moe, 1'b1)
        `CHK({cho, cmo}, 6'h0a)
        {coe, cne} <= 6'h00;
        cyc(3);
        `CHK({cho, cmo}, 6'h20)
        {coe, cne} <= 6'h3f;
        dead(8'h01, n1);
        dead(8'h05, n5);
        `CHK(n5 - n1, 4)
        com[0] <= OCM_FORCE_ACT;
        rce[0] <= 1'b1;
        cyc(12);
        `CHK(cho[0], 1'b1)
        fet <= 1'b1;
        cyc(1);
        fet <= 1'b0;
        cyc(12);
        `CHK(cho[0], 1'b0)
        sms <= SM_RESET;
        sti <= 1'b1;
        cyc(12);
        `CHK(cho[0], 1'b1)
        ben <= 1'b1;
        for (int s = 0; s < 3; s++) begin
            bpol <= (s != 2);
            bin <= (s == 0);
            cfail <= (s == 1);
            cyc(3);
            `CHK(moe, 1'b0)
            `CHK({cho, cmo}, 6'h2a)
            bin <= (s == 2);
            cfail <= 1'b0;
            cyc(2);
            mset <= 1'b1;
            cyc(1);
            mset <= 1'b0;
            cyc(3);
            `CHK(moe, 1'b1)
        end
        `CHK(brk_n, 3)
        // single pulse: output rises after compare ticks, then freezes low
        dead_time_setting <= 8'h00;
        arv <= 16'h0003;
        com[0] <= OCM_PWM2;
        spe <= 1'b1;
        ticks(1);
        `CHK(cho[0], 1'b0)
        ticks(1);
        `CHK(cho[0], 1'b1)
        ticks(2);
        `CHK({run, cho[0]}, 2'b00)
        com[0] <= OCM_FORCE_ACT;
        cyc(3);
        `CHK(cho[0], 1'b1)
        cds[0] <= 2'h1;
        cyc(3);
        `CHK(cho[0], 1'b0)
        mclr <= 1'b1;
        cyc(1);
        mclr <= 1'b0;
        cyc(2);
        `CHK(moe, 1'b0)
        `CHK({cho, cmo}, 6'h2a)
        `CHK(ovl, 1'b0)
        finish_test();
    end
endmodule : tb_top
